// ---- rtl/ssdc_consts.svh ----
// constants of the stepper stall detector control block
// assumes byte-wide register port with a 3-bit offset
`ifndef SSDC_CONSTS_SVH
`define SSDC_CONSTS_SVH

// =====================================================
// register offsets
`define SSDC_OFF_RTZ_CTL   3'h0
`define SSDC_OFF_MDC_CTL   3'h1
`define SSDC_OFF_DET_CTL   3'h2
`define SSDC_OFF_DET_FLG   3'h3
`define SSDC_OFF_MDC_HI    3'h4
`define SSDC_OFF_MDC_LO    3'h5
`define SSDC_OFF_SUM_HI    3'h6
`define SSDC_OFF_SUM_LO    3'h7

// =====================================================
// return_to_zero_control fields
`define SSDC_RTZ_ITG       7
`define SSDC_RTZ_DRIVE_COIL_ENABLE     6
`define SSDC_RTZ_RECIRC_SIDE_SELECT      5
`define SSDC_RTZ_POL       4
`define SSDC_RTZ_RETURN_TO_ZERO_ENABLE      3
`define SSDC_RTZ_SMS       2

// down_counter_control fields
`define SSDC_MDC_ZIE       7
`define SSDC_MDC_EN        6
`define SSDC_MDC_RELOAD    5

// detector_control / detector_flags fields
`define SSDC_DET_EN        7
`define SSDC_FLG_ZERO      0

// =====================================================
// reset values
`define SSDC_RST_BYTE      8'h00
`define SSDC_RST_WORD      16'h0000

`endif

// ---- rtl/ssdc_pkg.sv ----
// types of the stepper stall detector control block
// assumes ssdc_consts.svh is used beside it for numbers
package ssdc_pkg;

    typedef enum logic [1:0] {
        ssdc_east,
        ssdc_north,
        ssdc_west,
        ssdc_south
    } ssdc_step_e;

    typedef logic [7:0]  ssdc_byte_t;
    typedef logic [15:0] ssdc_word_t;

endpackage : ssdc_pkg

// ---- rtl/ssdc_ctrl.sv ----
// stepper stall detector control: coil transistors, converter switches,
// integrator accumulator and modulus down counter behind a byte register port
// assumes one 20 MHz clock; sd_bit comes asynchronously from the converter
`timescale 1ns/1ps
`include "ssdc_consts.svh"

// Operation
// - integration result held in 16-bit readable accumulator
// - integrate only after blanking interval ends
// - 16-bit modulus down counter times intervals
// - down counter underflow raises interrupt request
// - at most one coil driven during return
// - two motors multiplexed on coils and detector
// - eight byte offsets, 0x0 to 0x7
// - address is chip base plus offset
// - accumulator high 0x6, low 0x7, read-only
// - bit 7: non-driven when set, else recirculated
// - integrate set: coil ends to reference, integrator
// - integrate clear: blanking, converter reset, sum cleared
// - bit 6 drives step coil, else drivers off
// - bit 5 recirculation: high side or low side
// - bit 4 picks coil end to converter
// - control register readable and writable anytime
// - bits 1:0 full step 0/90/180/270 degrees
// - bit 2 selects motor A or B
module ssdc_ctrl
    import ssdc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [2:0]        addr,
    input  wire ssdc_pkg::ssdc_byte_t wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output ssdc_pkg::ssdc_byte_t   rdata,
    input  wire logic              sd_bit,
    output logic                   sd_reset,
    output logic [7:0]             trans_a,
    output logic [7:0]             trans_b,
    output logic [7:0]             switch_a,
    output logic [7:0]             switch_b,
    output logic                   irq
);
    import ssdc_pkg::*;

    // =====================================================
    // register storage
    ssdc_byte_t return_to_zero_control;
    ssdc_byte_t down_counter_control;
    ssdc_byte_t detector_control;
    logic       zero_flag;
    ssdc_word_t modulus;
    ssdc_word_t down_counter_value;
    ssdc_word_t integrator_sum;

    // =====================================================
    // decode; the chip adds the base, the block sees only the offset
    wire        wr_rtz  = wr && (addr == `SSDC_OFF_RTZ_CTL);
    wire        wr_mdc  = wr && (addr == `SSDC_OFF_MDC_CTL);
    wire        wr_det  = wr && (addr == `SSDC_OFF_DET_CTL);
    wire        wr_flg  = wr && (addr == `SSDC_OFF_DET_FLG);
    wire        wr_hi   = wr && (addr == `SSDC_OFF_MDC_HI);
    wire        wr_lo   = wr && (addr == `SSDC_OFF_MDC_LO);

    wire        integrate_select   = return_to_zero_control[`SSDC_RTZ_ITG];
    wire        drive_coil_enable  = return_to_zero_control[`SSDC_RTZ_DRIVE_COIL_ENABLE];
    wire        recirc_side_select = return_to_zero_control[`SSDC_RTZ_RECIRC_SIDE_SELECT];
    wire        coil_end_polarity  = return_to_zero_control[`SSDC_RTZ_POL];
    wire        return_to_zero_enable = return_to_zero_control[`SSDC_RTZ_RETURN_TO_ZERO_ENABLE];
    wire        motor_select       = return_to_zero_control[`SSDC_RTZ_SMS];
    wire ssdc_step_e step          = ssdc_step_e'(return_to_zero_control[1:0]);
    wire        det_en             = detector_control[`SSDC_DET_EN];

    // =====================================================
    // transistor pattern, bit 0 is T1 ... bit 7 is T8
    // the step picks one coil to drive and the other one to blank
    logic [7:0] drive_pat;
    logic [7:0] recirc_pat;
    logic [7:0] trans_pat;

    always_comb
    begin
        case (step)
            ssdc_east:
            begin
                drive_pat  = 8'h09;
                recirc_pat = recirc_side_select ? 8'hA0 : 8'h50;
            end
            ssdc_north:
            begin
                drive_pat  = 8'h90;
                recirc_pat = recirc_side_select ? 8'h0A : 8'h05;
            end
            ssdc_west:
            begin
                drive_pat  = 8'h06;
                recirc_pat = recirc_side_select ? 8'hA0 : 8'h50;
            end
            ssdc_south:
            begin
                drive_pat  = 8'h60;
                recirc_pat = recirc_side_select ? 8'h0A : 8'h05;
            end
            default:
            begin
                drive_pat  = 8'h00;
                recirc_pat = 8'h00;
            end
        endcase
        // only the step coil may be driven; the other is blanked or floats
        trans_pat = 8'h00;
        if (return_to_zero_enable)
        begin
            if (drive_coil_enable)
                trans_pat = drive_pat;
            if (!integrate_select)
                trans_pat = trans_pat | recirc_pat;
        end
    end

    // =====================================================
    // converter switch pattern, bit 0 is S1 ... bit 7 is S8
    // independent of the return enable
    logic [7:0] switch_pat;

    always_comb
    begin
        case (step)
            ssdc_east:  switch_pat = coil_end_polarity ? 8'h60 : 8'h90;
            ssdc_north: switch_pat = coil_end_polarity ? 8'h09 : 8'h06;
            ssdc_west:  switch_pat = coil_end_polarity ? 8'h90 : 8'h60;
            ssdc_south: switch_pat = coil_end_polarity ? 8'h06 : 8'h09;
            default:    switch_pat = 8'h00;
        endcase
        if (!integrate_select)
            switch_pat = 8'h00;
    end

    // =====================================================
    // converter input synchroniser; a change counts once stages 2 and 3 agree
    logic sd_s1;
    logic sd_s2;
    logic sd_s3;
    logic sd_level;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sd_s1    <= 1'b0;
            sd_s2    <= 1'b0;
            sd_s3    <= 1'b0;
            sd_level <= 1'b0;
        end
        else
        begin
            sd_s1 <= sd_bit;
            sd_s2 <= sd_s1;
            sd_s3 <= sd_s2;
            if (sd_s2 == sd_s3)
                sd_level <= sd_s3;
        end
    end

    // =====================================================
    // integrator: up on a one, down on a zero, cleared while blanking
    // wraps rather than saturates; software keeps windows short enough
    wire        integrating = integrate_select && det_en;
    wire ssdc_word_t next_sum = sd_level ? (integrator_sum + 16'h0001)
                                         : (integrator_sum - 16'h0001);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            integrator_sum <= `SSDC_RST_WORD;
        else if (!integrate_select)
            integrator_sum <= `SSDC_RST_WORD;
        else if (integrating)
            integrator_sum <= next_sum;
    end

    // =====================================================
    // modulus down counter; a count write loads both modulus and counter
    wire        mdc_en     = down_counter_control[`SSDC_MDC_EN];
    wire        mdc_reload = down_counter_control[`SSDC_MDC_RELOAD];
    wire        at_zero    = (down_counter_value == 16'h0000);
    wire        underflow  = mdc_en && at_zero && !wr_hi && !wr_lo;
    wire ssdc_word_t next_modulus = wr_hi ? {wdata, modulus[7:0]}
                                  : wr_lo ? {modulus[15:8], wdata}
                                  : modulus;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            modulus            <= `SSDC_RST_WORD;
            down_counter_value <= `SSDC_RST_WORD;
        end
        else if (wr_hi || wr_lo)
        begin
            modulus            <= next_modulus;
            down_counter_value <= next_modulus;
        end
        else if (underflow)
            down_counter_value <= mdc_reload ? modulus : 16'h0000;
        else if (mdc_en)
            down_counter_value <= down_counter_value - 16'h0001;
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            zero_flag <= 1'b0;
        else if (underflow && !zero_flag)
            zero_flag <= 1'b1;
        else if (underflow)
            zero_flag <= 1'b1;
        else if (wr_flg && wdata[`SSDC_FLG_ZERO])
            zero_flag <= 1'b0;
    end

    // =====================================================
    // control registers, writable at any time
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            return_to_zero_control <= `SSDC_RST_BYTE;
            down_counter_control   <= `SSDC_RST_BYTE;
            detector_control       <= `SSDC_RST_BYTE;
        end
        else
        begin
            if (wr_rtz)
                return_to_zero_control <= wdata;
            if (wr_mdc)
                down_counter_control <= {wdata[7:5], 5'h00};
            if (wr_det)
                detector_control <= {wdata[7], 7'h00};
        end
    end

    // =====================================================
    // read mux; accumulator bytes have no write path
    ssdc_byte_t rd_mux;

    always_comb
    begin
        case (addr)
            `SSDC_OFF_RTZ_CTL: rd_mux = return_to_zero_control;
            `SSDC_OFF_MDC_CTL: rd_mux = down_counter_control;
            `SSDC_OFF_DET_CTL: rd_mux = detector_control;
            `SSDC_OFF_DET_FLG: rd_mux = {7'h00, zero_flag};
            `SSDC_OFF_MDC_HI:  rd_mux = down_counter_value[15:8];
            `SSDC_OFF_MDC_LO:  rd_mux = down_counter_value[7:0];
            `SSDC_OFF_SUM_HI:  rd_mux = integrator_sum[15:8];
            `SSDC_OFF_SUM_LO:  rd_mux = integrator_sum[7:0];
            default:           rd_mux = 8'h00;
        endcase
    end

    // =====================================================
    // registered outputs; the unselected motor sees everything off
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata    <= 8'h00;
            sd_reset <= 1'b1;
            trans_a  <= 8'h00;
            trans_b  <= 8'h00;
            switch_a <= 8'h00;
            switch_b <= 8'h00;
            irq      <= 1'b0;
        end
        else
        begin
            rdata    <= rd ? rd_mux : 8'h00;
            sd_reset <= !integrate_select;
            trans_a  <= motor_select ? 8'h00 : trans_pat;
            trans_b  <= motor_select ? trans_pat : 8'h00;
            switch_a <= motor_select ? 8'h00 : switch_pat;
            switch_b <= motor_select ? switch_pat : 8'h00;
            irq      <= zero_flag && down_counter_control[`SSDC_MDC_ZIE];
        end
    end

endmodule : ssdc_ctrl

// ---- verif/ssdc_ctrl_sva.sv ----
// port assertions for the stall detector control block
// assumes binding to ssdc_ctrl; control byte is shadowed from the write strobe
`timescale 1ns/1ps
module ssdc_ctrl_sva
(
    input wire logic                 clk,
    input wire logic                 resetn,
    input wire logic [2:0]           addr,
    input wire ssdc_pkg::ssdc_byte_t wdata,
    input wire logic                 wr,
    input wire logic                 rd,
    input wire ssdc_pkg::ssdc_byte_t rdata,
    input wire logic                 sd_reset,
    input wire logic [7:0]           trans_a,
    input wire logic [7:0]           trans_b,
    input wire logic [7:0]           switch_a,
    input wire logic [7:0]           switch_b
);
    import ssdc_pkg::*;
    ssdc_byte_t ctl;
    wire logic [7:0] tr = trans_a | trans_b;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            ctl <= 8'h00;
        else if (wr && addr == 3'h0)
            ctl <= wdata;
    // =========================================
    // register port and coil outputs
    AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside read cycle");
    AST_RD_CTL: assert property ($past(rd && addr == 3'h0) |-> rdata == $past(ctl))
        else $error("control readback differs");
    AST_NO_RTZ: assert property (!$past(ctl[3]) |-> tr == 8'h00)
        else $error("coil driven outside return");
    AST_BLANK: assert property (!$past(ctl[7]) |-> sd_reset && (switch_a | switch_b) == 8'h00)
        else $error("blanking not held");
    AST_INTEG: assert property ($past(ctl[7]) |-> !sd_reset && $countones(switch_a | switch_b) == 2)
        else $error("coil not routed to converter");
    AST_MUX_B: assert property ($past(ctl[2]) |-> (trans_a | switch_a) == 8'h00)
        else $error("motor a active while b selected");
    AST_MUX_A: assert property (!$past(ctl[2]) |-> (trans_b | switch_b) == 8'h00)
        else $error("motor b active while a selected");
    AST_ONE_COIL: assert property ($past(ctl[7] && ctl[3]) |-> tr[3:0] == 4'h0 || tr[7:4] == 4'h0)
        else $error("both coils driven");
endmodule : ssdc_ctrl_sva

bind ssdc_ctrl ssdc_ctrl_sva chk (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sd_reset(sd_reset), .trans_a(trans_a),
    .trans_b(trans_b), .switch_a(switch_a), .switch_b(switch_b));

// ---- verif/ssdc_coil_model.sv ----
// coil and converter stand-in for motors a and b
// assumes emf gives the sign of the back-EMF on whichever coil is routed
`timescale 1ns/1ps
module ssdc_coil_model
(
    input wire logic       clk,
    input wire logic [7:0] switch_a,
    input wire logic [7:0] switch_b,
    input wire logic       emf,
    output logic           sd_bit
);
    initial sd_bit = 1'b0;
    // open switches leave the comparator floating, so it toggles
    always @(posedge clk)
        sd_bit <= (|(switch_a | switch_b)) ? emf : ~sd_bit;
endmodule : ssdc_coil_model

// ---- verif/tb.sv ----
// self-checking bench for the stall detector control block
// assumes the byte register port of ssdc_ctrl and the coil model beside it
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
    import ssdc_pkg::*;
    logic            clk = 0, resetn = 0, wr = 0, rd = 0, emf = 1, sd_bit, sd_reset, irq;
    logic [2:0]      addr = 0;
    ssdc_byte_t      wdata = 0, rdata, got, c;
    logic [7:0]      trans_a, trans_b, switch_a, switch_b, t, s;
    ssdc_word_t      s1, s2, s3;
    int              n_mismatch = 0, total_checks = 0, n;
    always #25 clk = ~clk;
    ssdc_ctrl dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .sd_bit(sd_bit), .sd_reset(sd_reset), .trans_a(trans_a),
        .trans_b(trans_b), .switch_a(switch_a), .switch_b(switch_b), .irq(irq));
    ssdc_coil_model far (.clk(clk), .switch_a(switch_a), .switch_b(switch_b),
        .emf(emf), .sd_bit(sd_bit));
    // =========================================
    // access tasks
    task automatic wr_reg(input logic [2:0] a, input ssdc_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask : rd_reg
    task automatic rd_sum(output ssdc_word_t v);
        rd_reg(3'h6);
        v[15:8] = got;
        rd_reg(3'h7);
        v[7:0] = got;
    endtask : rd_sum
    // fixed-length integration window, so equal windows give equal counts
    task automatic window();
        wr_reg(3'h2, 8'h80);
        repeat (20) @(posedge clk);
        wr_reg(3'h2, 8'h00);
    endtask : window
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // step: 0 east, 1 north, 2 west, 3 south
    function automatic logic [7:0] exp_tr(input ssdc_byte_t k);
        logic [7:0] d, r;
        d = k[0] ? (k[1] ? 8'h60 : 8'h90) : (k[1] ? 8'h06 : 8'h09);
        r = k[0] ? (k[5] ? 8'h0A : 8'h05) : (k[5] ? 8'hA0 : 8'h50);
        return k[3] ? ((k[6] ? d : 8'h00) | (k[7] ? 8'h00 : r)) : 8'h00;
    endfunction : exp_tr
    function automatic logic [7:0] exp_sw(input ssdc_byte_t k);
        logic x;
        x = k[1] ^ k[4];
        if (!k[7])
            return 8'h00;
        return k[0] ? (x ? 8'h09 : 8'h06) : (x ? 8'h60 : 8'h90);
    endfunction : exp_sw
    initial
    begin
        #500000;
        n_mismatch++;
        wrap_up();
    end
    // =========================================
    // tests
    initial
    begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        #1 `CHK("reset coils", 17'h10000, {sd_reset, trans_a | trans_b, switch_a | switch_b})
        for (int i = 0; i < 8; i++)
        begin
            rd_reg(i[2:0]);
            `CHK("reset reg", 8'h00, got)
        end
        $display("reset test done");
        for (int i = 0; i < 256; i++)
        begin
            c = i[7:0];
            t = exp_tr(c);
            s = exp_sw(c);
            wr_reg(3'h0, c);
            @(posedge clk);
            #1 `CHK("trans", c[2] ? {t, 8'h00} : {8'h00, t}, {trans_b, trans_a})
            `CHK("switch", c[2] ? {s, 8'h00} : {8'h00, s}, {switch_b, switch_a})
            `CHK("sd_reset", ~c[7], sd_reset)
            rd_reg(3'h0);
            `CHK("control", c, got)
        end
        $display("coil test done");
        wr_reg(3'h0, 8'h88);
        window();
        rd_sum(s1);
        `CHK("sum span", 1'b1, s1 >= 16'd20 && s1 <= 16'd24)
        window();
        rd_sum(s2);
        `CHK("sum up", s1 + s1, s2)
        emf <= 1'b0;
        repeat (8) @(posedge clk);
        window();
        rd_sum(s3);
        `CHK("sum down", s1, s3)
        wr_reg(3'h6, 8'hFF);
        wr_reg(3'h7, 8'hFF);
        rd_sum(s3);
        `CHK("sum read only", s1, s3)
        wr_reg(3'h0, 8'h08);
        rd_sum(s3);
        `CHK("sum cleared", 16'h0000, s3)
        $display("integrator test done");
        wr_reg(3'h4, 8'h00);
        wr_reg(3'h5, 8'h06);
        rd_reg(3'h5);
        `CHK("modulus", 8'h06, got)
        wr_reg(3'h1, 8'hC0);
        n = 0;
        while (irq !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            #1 n++;
        end
        `CHK("count span", 1'b1, n >= 5 && n <= 10)
        `CHK("irq raised", 1'b1, irq)
        wr_reg(3'h1, 8'h40);
        repeat (2) @(posedge clk);
        #1 `CHK("irq masked", 1'b0, irq)
        rd_reg(3'h3);
        `CHK("flag set", 1'b1, got[0])
        wr_reg(3'h1, 8'h00);
        wr_reg(3'h3, 8'h01);
        rd_reg(3'h3);
        `CHK("flag cleared", 1'b0, got[0])
        $display("counter test done");
        wrap_up();
    end
endmodule : tb
